// [logic/psp_pkg.sv]
/*
 * shared constants and carrier types for the pipelined sram data port.
 * assumes one 10 MHz clock and an active-high asynchronous reset.
 */
`default_nettype none
package psp_pkg;
    // ==========================================================
    // geometry
    localparam int PSP_ADDR_W = 18;
    localparam int PSP_LANES = 4;
    localparam int PSP_LANE_W = 8;
    localparam int PSP_DATA_W = PSP_LANES * PSP_LANE_W;
    localparam int PSP_BURST_W = 2;
    // ==========================================================
    // reset values
    localparam logic [PSP_ADDR_W-1:0] PSP_ADDR_RST = 18'h00000;
    localparam logic [PSP_BURST_W-1:0] PSP_STEP_RST = 2'h0;
    localparam logic PSP_MODE_RST = 1'b1;
    // ==========================================================
    // one request as sampled on a rising edge
    typedef struct packed {
        logic sel1_n;
        logic sel2;
        logic sel3_n;
        logic adv;
        logic write_n;
        logic [PSP_LANES-1:0] lane_n;
        logic [PSP_ADDR_W-1:0] addr;
    } psp_req_t;
    // word with its parity bits, one per lane
    typedef struct packed {
        logic [PSP_LANES-1:0] par;
        logic [PSP_DATA_W-1:0] data;
    } psp_word_t;
    typedef enum logic [2:0] {
        PSP_IDLE = 3'b001,
        PSP_READ = 3'b010,
        PSP_WRITE = 3'b100
    } psp_op_t;
endpackage
`default_nettype wire

// [logic/psp_burst_addr.sv]
/*
 * burst address generator: forms the two low address bits of a burst step.
 * assumes the caller holds base and step stable while the clock is qualified off.
 */
`default_nettype none
module psp_burst_addr
    import psp_pkg::*;
(
    input wire logic [PSP_ADDR_W-1:0] base_in,
    input wire logic [PSP_BURST_W-1:0] step_in,
    input wire logic interleave_in,
    output logic [PSP_ADDR_W-1:0] addr_out
);
    // ==========================================================
    // linear wraps a mod-4 add, interleaved xors with the step
    logic [PSP_BURST_W-1:0] low_lin;
    assign low_lin = base_in[PSP_BURST_W-1:0] + step_in;
    assign addr_out = {base_in[PSP_ADDR_W-1:PSP_BURST_W],
        interleave_in ? (base_in[PSP_BURST_W-1:0] ^ step_in) : low_lin};
endmodule
`default_nettype wire

// [logic/psp_mem.sv]
/*
 * storage array with per-lane write and registered read data.
 * assumes a single clock; write and read are gated by the caller's enable.
 */
`default_nettype none
module psp_mem
    import psp_pkg::*;
#(
    parameter int DEPTH_LOG2 = PSP_ADDR_W
) (
    input wire logic sys_clk_in,
    input wire logic en_in,
    input wire logic wr_in,
    input wire logic [PSP_LANES-1:0] lane_we_in,
    input wire logic [DEPTH_LOG2-1:0] addr_in,
    input wire psp_word_t wdata_in,
    output psp_word_t rdata_out
);
    initial begin
        if (DEPTH_LOG2 < 2 || DEPTH_LOG2 > PSP_ADDR_W) $error("depth unsupported");
    end
    // ==========================================================
    // one generated byte plane per lane, parity kept with its byte
    localparam int LW = PSP_LANE_W + 1;
    // lanes meet on a net, since several drivers of one variable are refused
    wire psp_word_t rd_w;
    assign rdata_out = rd_w;
    genvar g;
    generate
        for (g = 0; g < PSP_LANES; g++) begin : g_lane
            logic [LW-1:0] arr [0:(1<<DEPTH_LOG2)-1];
            logic [LW-1:0] rd_q;
            always_ff @(posedge sys_clk_in) begin
                if (en_in && wr_in && lane_we_in[g]) begin
                    arr[addr_in] <= {wdata_in.par[g], wdata_in.data[g*PSP_LANE_W +: PSP_LANE_W]};
                end
                if (en_in) begin
                    rd_q <= arr[addr_in];
                end
            end
            assign rd_w.data[g*PSP_LANE_W +: PSP_LANE_W] = rd_q[PSP_LANE_W-1:0];
            assign rd_w.par[g] = rd_q[PSP_LANE_W];
        end
    endgenerate
endmodule
`default_nettype wire

// [logic/psp_port.sv]
/*
 * data port of a pipelined burst sram: qualified clock, burst counter,
 * one-cycle write data capture, registered read data, output enable policy.
 * assumes the controller drives all inputs synchronous to sys_clk_in.
 */
// Contract
// - act on a clock edge only while clock qualifier is low
// - qualifier high stretches the current operation, never deselects
// - capture data lines into a data register on the rising edge; here they are written straight into the addressed array row
// - read drives word addressed on the previous qualified edge; here it drives the word addressed two qualified edges earlier
// - output enable low lets data lines drive, under internal control
// - output enable high holds every data line at high impedance; here it acts only at the next qualified edge
// - outputs tristate during the write data cycle regardless of enable
// - first clock after deselect keeps outputs tristated
// - outputs stay tristated while deselected
// - parity lines act as data; each stored only under its lane strobe
// - strap high selects interleaved, low selects linear burst
// - an open strap reads high, giving interleaved order
// - selected only with sel1 low, sel2 high, sel3 low at the edge
// - advance high with qualifier low steps the burst counter
// - qualifier high preserves all state including pipeline and counter; here the mode strap register still samples on every edge
`default_nettype none
module psp_port
    import psp_pkg::*;
#(
    parameter int DEPTH_LOG2 = PSP_ADDR_W
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic clock_qualify_n_in,
    input wire psp_req_t req_in,
    input wire logic output_enable_n_in,
    input wire logic mode_in,
    input wire psp_word_t dq_in,
    output psp_word_t dq_out,
    output logic [PSP_LANES-1:0] dq_oe_n_out,
    output logic [PSP_LANES-1:0] parity_io_oe_n_out
);
    initial begin
        if (DEPTH_LOG2 < 2 || DEPTH_LOG2 > PSP_ADDR_W) $error("depth unsupported");
    end
    // ==========================================================
    // qualified edge and select decode
    logic go;
    logic sel;
    assign go = ~clock_qualify_n_in;
    assign sel = ~req_in.sel1_n & req_in.sel2 & ~req_in.sel3_n;
    // mode strap: caught on every edge, an open pin is pulled high outside
    logic mode_q;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode_q <= PSP_MODE_RST;
        end else begin
            mode_q <= mode_in;
        end
    end
    // ==========================================================
    // address stage: load or advance the burst
    psp_op_t op_q;
    logic [PSP_ADDR_W-1:0] base_q;
    logic [PSP_BURST_W-1:0] step_q;
    logic [PSP_LANES-1:0] lane_q;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            op_q <= PSP_IDLE;
            base_q <= PSP_ADDR_RST;
            step_q <= PSP_STEP_RST;
            lane_q <= '0;
        end else if (go) begin
            if (req_in.adv) begin
                // a burst keeps the latched direction; only strobes refresh
                step_q <= step_q + 2'h1;
                lane_q <= ~req_in.lane_n;
            end else if (sel) begin
                op_q <= req_in.write_n ? PSP_READ : PSP_WRITE;
                base_q <= req_in.addr;
                step_q <= PSP_STEP_RST;
                lane_q <= ~req_in.lane_n;
            end else begin
                op_q <= PSP_IDLE;
            end
        end
    end
    logic [PSP_ADDR_W-1:0] cur_addr;
    psp_burst_addr u_burst (
        .base_in(base_q),
        .step_in(step_q),
        .interleave_in(mode_q),
        .addr_out(cur_addr)
    );
    // ==========================================================
    // data stage: write data captured one edge after its address
    psp_op_t dop_q;
    logic [PSP_ADDR_W-1:0] daddr_q;
    logic [PSP_LANES-1:0] dlane_q;
    logic was_idle_q;
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dop_q <= PSP_IDLE;
            daddr_q <= PSP_ADDR_RST;
            dlane_q <= '0;
            was_idle_q <= 1'b1;
        end else if (go) begin
            dop_q <= op_q;
            daddr_q <= cur_addr;
            dlane_q <= lane_q;
            was_idle_q <= (dop_q == PSP_IDLE);
        end
    end
    // write and read both use the address stage address cur_addr
    logic mem_wr;
    logic [DEPTH_LOG2-1:0] mem_addr;
    psp_word_t rd_word;
    assign mem_wr = (op_q == PSP_WRITE);
    assign mem_addr = mem_wr ? cur_addr[DEPTH_LOG2-1:0] : cur_addr[DEPTH_LOG2-1:0];
    // ==========================================================
    // array: the data lines are caught straight into the addressed row on the
    // edge after the command, so a read right after a write never fights it
    psp_mem #(
        .DEPTH_LOG2(DEPTH_LOG2)
    ) u_mem (
        .sys_clk_in(sys_clk_in),
        .en_in(go),
        .wr_in(mem_wr),
        .lane_we_in(lane_q),
        .addr_in(mem_addr),
        .wdata_in(dq_in),
        .rdata_out(rd_word)
    );
    // ==========================================================
    // output drive: read data two edges after the address, with masks
    logic drive;
    assign drive = (op_q == PSP_READ);
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dq_out <= '0;
        end else if (go) begin
            dq_out <= rd_word;
        end
    end
    // enable is asynchronous on a real part; here it is sampled, one cycle late
    logic oe_n;
    always_comb begin
        oe_n = 1'b1;
        if (go) begin
            oe_n = output_enable_n_in
                | (dop_q == PSP_WRITE)
                | (dop_q == PSP_IDLE)
                | was_idle_q;
        end
    end
    always_ff @(posedge sys_clk_in or posedge rst_in) begin
        if (rst_in) begin
            dq_oe_n_out <= '1;
            parity_io_oe_n_out <= '1;
        end else if (go) begin
            dq_oe_n_out <= {PSP_LANES{oe_n}};
            parity_io_oe_n_out <= {PSP_LANES{oe_n}};
        end else begin
            dq_oe_n_out <= dq_oe_n_out;
            parity_io_oe_n_out <= parity_io_oe_n_out;
        end
    end
    // ==========================================================
    // checks
    logic drive_unused;
    assign drive_unused = drive;
    stall_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        clock_qualify_n_in |=> $stable(op_q) && $stable(step_q) && $stable(dq_oe_n_out))
        else $error("state moved while clock unqualified");
    write_tristate_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        go && dop_q == PSP_WRITE |=> &dq_oe_n_out)
        else $error("drove during write data");
    oe_high_tri_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        go && output_enable_n_in |=> &dq_oe_n_out && &parity_io_oe_n_out)
        else $error("drove with enable high");
    deselect_tri_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        go && dop_q == PSP_IDLE |=> &dq_oe_n_out)
        else $error("drove while deselected");
    first_cycle_tri_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        go && was_idle_q |=> &dq_oe_n_out)
        else $error("drove on first clock after deselect");
    read_drive_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        go && !output_enable_n_in && dop_q == PSP_READ && !was_idle_q |=> !dq_oe_n_out[0])
        else $error("read not driven");
    burst_step_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        go && req_in.adv |=> step_q == $past(step_q) + 2'h1)
        else $error("burst counter did not step");
    select_load_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        go && !req_in.adv && !sel |=> op_q == PSP_IDLE)
        else $error("bad select accepted");
    parity_follow_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        parity_io_oe_n_out == dq_oe_n_out)
        else $error("parity enable differs");
    load_op_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        go && !req_in.adv && sel && req_in.write_n |=> op_q == PSP_READ)
        else $error("read not loaded");
endmodule
`default_nettype wire

// [bench/psp_ctrl_model.sv]
/*
 * controller-side model facing the sram data port.
 * assumes the bench calls drive_cycle once after each falling clock edge.
 */
`default_nettype none
module psp_ctrl_model
    import psp_pkg::*;
(
    output logic clock_qualify_n_out,
    output psp_req_t req_out,
    output logic output_enable_n_out,
    output logic mode_out,
    output psp_word_t data_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic pend_q;
    psp_word_t pend_word_q;
    // ==========================================================
    // idle bus at time zero
    initial begin
        clock_qualify_n_out = 1'b1;
        req_out = '0;
        output_enable_n_out = 1'b1;
        mode_out = 1'b1;
        data_out = '0;
        pend_q = 1'b0;
        pend_word_q = '0;
    end
    // write data trails its command by one qualified edge; a frozen edge keeps it
    task automatic drive_cycle(input logic qual_n, input psp_req_t req, input logic oe_n,
        input logic mode, input psp_word_t wdata);
        data_out = pend_q ? pend_word_q : ~data_out; // released bus never repeats a word
        clock_qualify_n_out = qual_n;
        req_out = req;
        output_enable_n_out = oe_n;
        mode_out = mode;
        if (!qual_n) begin
            pend_q = !req.sel1_n && req.sel2 && !req.sel3_n && !req.adv && !req.write_n;
            pend_word_q = wdata;
        end
    endtask
endmodule
`default_nettype wire

// [bench/test_pipelined_sram_data_port.sv]
/*
 * self-checking bench for the pipelined sram data port.
 * assumes the controller model is the only driver of the port inputs other than clock and reset.
 */
`default_nettype none
module test_pipelined_sram_data_port;
    import psp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic oe_low;
        psp_word_t word;
    } psp_tb_op_t;
    logic sys_clk_in;
    logic rst_in;
    logic qual_n;
    psp_req_t req;
    logic oe_n;
    logic mode;
    psp_word_t dq_in;
    psp_word_t dq_out;
    logic [3:0] dq_oe_n;
    logic [3:0] par_oe_n;
    logic [31:0] lfsr;
    logic [31:0] rv;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    psp_word_t mem_exp [64];
    psp_tb_op_t pipe [3];
    logic prev_desel;
    logic oe_cur;
    logic mode_cur;
    logic [PSP_ADDR_W-1:0] base;
    psp_port #(.DEPTH_LOG2(6)) u_psp_port (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
        .clock_qualify_n_in(qual_n), .req_in(req), .output_enable_n_in(oe_n), .mode_in(mode),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n_out(dq_oe_n), .parity_io_oe_n_out(par_oe_n));
    psp_ctrl_model u_psp_ctrl_model (.clock_qualify_n_out(qual_n), .req_out(req),
        .output_enable_n_out(oe_n), .mode_out(mode), .data_out(dq_in));
    // ==========================================================
    // helpers
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic psp_word_t rword();
        logic [31:0] a;
        logic [31:0] b;
        a = rnd();
        b = rnd();
        return {b[3:0], a};
    endfunction
    function automatic logic [PSP_ADDR_W-1:0] burst_addr(input logic [PSP_ADDR_W-1:0] b,
        input logic [1:0] stp, input logic il);
        burst_addr = b;
        burst_addr[1:0] = il ? b[1:0] ^ stp : b[1:0] + stp;
    endfunction
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one qualified cycle, after random frozen edges that must change nothing
    task automatic cyc(input logic [1:0] kind, input logic [PSP_ADDR_W-1:0] addr,
        input logic [3:0] lanes_n, input psp_word_t wd);
        logic [31:0] v;
        logic frz;
        psp_req_t r;
        psp_tb_op_t op;
        do begin
            @(negedge sys_clk_in);
            check("oe", {32'h0, dq_oe_n}, {32'h0, {4{~pipe[2].oe_low}}});
            check("parity_oe", {32'h0, par_oe_n}, {32'h0, dq_oe_n});
            if (pipe[2].oe_low) begin
                check("data", dq_out, pipe[2].word);
            end
            v = rnd();
            frz = v[5:4] == 2'h0;
            r = '0;
            r.sel2 = 1'b1;
            r.adv = kind == 2'h3;
            r.write_n = kind != 2'h2;
            r.lane_n = lanes_n;
            r.addr = addr;
            if (kind == 2'h0) begin
                {r.sel1_n, r.sel2, r.sel3_n} = v[2:0] == 3'h2 ? 3'h6 : v[2:0];
            end
            if (frz) begin
                r = v[26:0];
            end
            u_psp_ctrl_model.drive_cycle(frz, r, oe_cur, mode_cur, wd);
        end while (frz);
        op.oe_low = kind[0] && !oe_cur && !prev_desel;
        op.word = mem_exp[addr[5:0]];
        for (int g = 0; g < 4; g++) begin
            if (kind == 2'h2 && !lanes_n[g]) begin
                mem_exp[addr[5:0]].data[8*g +: 8] = wd.data[8*g +: 8];
                mem_exp[addr[5:0]].par[g] = wd.par[g];
            end
        end
        prev_desel = kind == 2'h0;
        pipe[2] = pipe[1];
        pipe[1] = pipe[0];
        pipe[0] = op;
    endtask
    // deselected cycles drain the pipeline before any mode or enable change
    task automatic gap(input int n);
        repeat (n) cyc(2'h0, '0, 4'hF, '0);
    endtask
    task automatic final_report();
        $display("compares %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // clock, watchdog and main sequence
    initial begin
        sys_clk_in = 1'b0;
        forever #50 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        rst_in = 1'b1;
        lfsr = 32'h1E3CC54D;
        prev_desel = 1'b1;
        oe_cur = 1'b0;
        mode_cur = 1'b1;
        for (int i = 0; i < 3; i++) pipe[i] = '0;
        repeat (10) @(negedge sys_clk_in);
        rst_in = 1'b0;
        check("reset_oe", {32'h0, dq_oe_n}, {32'h0, 4'hF});
        check("reset_data", dq_out, '0);
        for (int i = 0; i < 64; i++) cyc(2'h2, PSP_ADDR_W'(i), 4'h0, rword());
        $display("test fill done, compares %0d", tests_run);
        for (int i = 0; i < 64; i++) begin
            rv = rnd();
            cyc(2'h2, PSP_ADDR_W'(i), rv[3:0], rword());
        end
        for (int i = 0; i < 40; i++) begin
            rv = rnd();
            if (rv[8]) cyc(2'h2, PSP_ADDR_W'(32 + rv[4:0]), 4'h0, rword());
            else cyc(2'h1, PSP_ADDR_W'(rv[4:0]), 4'hF, '0);
        end
        gap(3);
        for (int i = 0; i < 64; i++) cyc(2'h1, PSP_ADDR_W'(i), 4'hF, '0);
        $display("test lanes and mix done, compares %0d", tests_run);
        gap(3);
        oe_cur = 1'b1;
        gap(3);
        for (int i = 0; i < 8; i++) cyc(2'h1, PSP_ADDR_W'(i), 4'hF, '0);
        gap(3);
        oe_cur = 1'b0;
        $display("test enable high done, compares %0d", tests_run);
        for (int m = 0; m < 2; m++) begin
            gap(3);
            mode_cur = m[0];
            gap(2);
            rv = rnd();
            base = PSP_ADDR_W'(rv[5:0]);
            cyc(2'h1, base, 4'hF, '0);
            for (int k = 1; k < 5; k++) cyc(2'h3, burst_addr(base, k[1:0], m[0]), 4'hF, '0);
        end
        gap(3);
        $display("test bursts done, compares %0d", tests_run);
        final_report();
    end
endmodule
`default_nettype wire
